// ---- core/rf_channel_operation_control.v ----
// channel/operation register bank with operation state and packet indication
`timescale 1ns/100ps
`include "rf_chan_defs.vh"
module rf_channel_operation_control (
    // clock and reset
    input  wire        clock_in,
    input  wire        rstn_in,
    // spi pins
    input  wire        spi_select_n_in,
    input  wire        spi_clock_in,
    input  wire        spi_data_in,
    output wire        spi_data_out,
    output wire        spi_data_oe_out,
    // framer side
    input  wire        sync_detect_in,
    input  wire        fifo_threshold_in,
    input  wire [7:0]  rx_fifo_data_in,
    output reg         fifo_read_out,
    // radio control
    output reg         tx_enable_out,
    output reg         rx_enable_out,
    output reg  [6:0]  carrier_channel_index_out,
    output reg  [11:0] carrier_freq_mhz_out,
    output reg  [15:0] tx_power_step_out,
    // indication pins
    output reg         packet_indication_pin_out,
    output reg         fifo_flag_out,
    output reg         test_clock_out
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RX   = 2'h1;
    localparam [1:0] ST_TX   = 2'h2;

    reg  [15:0] chan_op_reg;
    reg  [15:0] test_cfg_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         capture_next;
    reg         pkt_done_reg;
    reg  [15:0] read_data;
    wire [15:0] status_w;
    wire [6:0]  addr_w;
    wire [15:0] wdata_w;
    wire        wstb_w;
    wire        rstb_w;
    wire        wr_op_w;
    // packet flag events
    wire        fifo_pop_w;
    wire        leave_rx_w;
    wire        pkt_set_w;
    wire        pkt_clear_w;

    // ------------------------------------------------------------
    // spi port
    // ------------------------------------------------------------
    spi_port_slave u_spi (
        .clock_in         (clock_in),
        .rstn_in          (rstn_in),
        .spi_select_n_in  (spi_select_n_in),
        .spi_clock_in     (spi_clock_in),
        .spi_data_in      (spi_data_in),
        .spi_data_out     (spi_data_out),
        .spi_data_oe_out  (spi_data_oe_out),
        .read_data_in     (read_data),
        .status_byte_in   (status_w[7:0]),
        .addr_out         (addr_w),
        .write_data_out   (wdata_w),
        .write_strobe_out (wstb_w),
        .read_strobe_out  (rstb_w)
    );

    assign wr_op_w = wstb_w && (addr_w == `REG_CHAN_OP);

    // status word: packet flag, receive and transmit activity
    assign status_w = {8'h00, packet_indication_pin_out, rx_enable_out, tx_enable_out,
                       5'h00};

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always @* begin
        case (addr_w)
            `REG_CHAN_OP:   read_data = chan_op_reg;
            `REG_TX_POWER:  read_data = tx_power_step_out;
            `REG_TEST_CFG:  read_data = test_cfg_reg;
            `REG_STATUS:    read_data = status_w;
            `REG_FIFO_DATA: read_data = {8'h00, rx_fifo_data_in};
            default:        read_data = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chan_op_reg       <= `CHAN_OP_RESET;
            tx_power_step_out <= `TX_POWER_RESET;
            test_cfg_reg      <= `TEST_CFG_RESET;
        end else if (wstb_w) begin
            case (addr_w)
                `REG_CHAN_OP:  chan_op_reg       <= wdata_w;
                `REG_TX_POWER: tx_power_step_out <= wdata_w;
                `REG_TEST_CFG: test_cfg_reg      <= wdata_w;
                default:       chan_op_reg       <= chan_op_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // operation state decided from each channel/operation write
    // ------------------------------------------------------------
    always @* begin
        state_next   = state_reg;
        capture_next = 1'b0;
        if (wr_op_w) begin
            case (state_reg)
                ST_IDLE: begin
                    if (wdata_w[`TX_START_BIT]) begin
                        state_next   = ST_TX;
                        capture_next = 1'b1;
                    end else if (wdata_w[`RX_START_BIT]) begin
                        state_next   = ST_RX;
                        capture_next = 1'b1;
                    end
                end
                ST_RX: begin
                    if (wdata_w[`RX_START_BIT] && !wdata_w[`TX_START_BIT]) begin
                        capture_next = 1'b1;
                    end else begin
                        // idle request, or a forbidden direction change
                        state_next = ST_IDLE;
                    end
                end
                ST_TX: begin
                    if (wdata_w[`TX_START_BIT] && !wdata_w[`RX_START_BIT]) begin
                        capture_next = 1'b1;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // state, enables and the captured channel
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg                 <= ST_IDLE;
            tx_enable_out             <= 1'b0;
            rx_enable_out             <= 1'b0;
            carrier_channel_index_out <= 7'h00;
            carrier_freq_mhz_out      <= `FREQ_BASE_MHZ;
        end else begin
            state_reg     <= state_next;
            tx_enable_out <= (state_next == ST_TX);
            rx_enable_out <= (state_next == ST_RX);
            if (capture_next) begin
                carrier_channel_index_out <= wdata_w[`CHAN_MSB:0];
                carrier_freq_mhz_out      <= `FREQ_BASE_MHZ
                                             + {5'h00, wdata_w[`CHAN_MSB:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // packet flag events
    // ------------------------------------------------------------
    // a read of the fifo data register pops one byte
    assign fifo_pop_w  = rstb_w && (addr_w == `REG_FIFO_DATA);
    // flag is held low whenever the coming state is not receive
    assign leave_rx_w  = (state_next != ST_RX);
    // sync found while armed sets the flag
    assign pkt_set_w   = sync_detect_in && !pkt_done_reg;
    // first byte read while the flag stands clears it
    assign pkt_clear_w = packet_indication_pin_out && fifo_pop_w;

    // ------------------------------------------------------------
    // packet indication: sync to first fifo read, once per operation
    // ------------------------------------------------------------
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            packet_indication_pin_out <= 1'b0;
            pkt_done_reg              <= 1'b0;
            fifo_read_out             <= 1'b0;
        end else begin
            fifo_read_out <= fifo_pop_w;
            if (capture_next && state_reg == ST_IDLE) begin
                // a new operation rearms the flag
                pkt_done_reg              <= 1'b0;
                packet_indication_pin_out <= 1'b0;
            end else if (leave_rx_w) begin
                // cleared together with the receive enable
                packet_indication_pin_out <= 1'b0;
            end else if (pkt_set_w) begin
                // set wins over a read in the same cycle
                packet_indication_pin_out <= 1'b1;
            end else if (pkt_clear_w) begin
                packet_indication_pin_out <= 1'b0;
                pkt_done_reg              <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // fifo flag pin and test clock output
    // ------------------------------------------------------------
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fifo_flag_out  <= 1'b0;
            test_clock_out <= 1'b0;
        end else begin
            fifo_flag_out <= fifo_threshold_in;
            if (test_cfg_reg[`TCLK_SEL_MSB:`TCLK_SEL_LSB] == `TCLK_SEL_REF) begin
                test_clock_out <= ~test_clock_out;
            end else begin
                test_clock_out <= 1'b0;
            end
        end
    end
endmodule

// ---- include/rf_chan_defs.vh ----
// register map, field positions, reset values and spi frame bit counts of the channel block
// How it works
// - carrier frequency in MHz is 2402 plus the programmed channel index
// - channel index is the low seven bits of the channel/operation register
// - bit 7 set starts receive, bit 8 set starts transmit
// - channel written with the start bit of the new or current direction sets the operation's frequency
// - writing both start bits clear makes the device leave transmit or receive
// - new channel in the same active direction retunes without passing idle
// - packet indication drives a pin and also shows in status register 48
// - reset pin low returns every internal register to its default
// - reference clock reaches test clock pin only when register 32[3:1] selects it
// - receive packet indication holds from sync until first FIFO byte is read
`ifndef RF_CHAN_DEFS_VH
`define RF_CHAN_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define REG_CHAN_OP        7'h07
`define REG_TX_POWER       7'h09
`define REG_TEST_CFG       7'h20
`define REG_STATUS         7'h30
`define REG_FIFO_DATA      7'h32

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CHAN_MSB           6
`define RX_START_BIT       7
`define TX_START_BIT       8
`define TCLK_SEL_MSB       3
`define TCLK_SEL_LSB       1
`define STAT_PKT_BIT       7
`define STAT_RX_BIT        6
`define STAT_TX_BIT        5
`define SPI_READ_BIT       7

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define CHAN_OP_RESET      16'h0000
`define TX_POWER_RESET     16'h0000
`define TEST_CFG_RESET     16'h0000
`define TCLK_SEL_REF       3'h1
`define FREQ_BASE_MHZ      12'h962
`define PIN_IDLE           3'h4

// ------------------------------------------------------------
// spi frame counts
// ------------------------------------------------------------
`define SPI_ADDR_LAST      5'h07
`define SPI_FRAME_LAST     5'h17

`endif

// ---- core/spi_port_slave.v ----
// spi slave: pin synchroniser, 8-bit command then 16-bit word, mode 0
`timescale 1ns/100ps
`include "rf_chan_defs.vh"
module spi_port_slave (
    // clock and reset
    input  wire        clock_in,
    input  wire        rstn_in,
    // spi pins
    input  wire        spi_select_n_in,
    input  wire        spi_clock_in,
    input  wire        spi_data_in,
    output reg         spi_data_out,
    output reg         spi_data_oe_out,
    // register side
    input  wire [15:0] read_data_in,
    input  wire [7:0]  status_byte_in,
    output reg  [6:0]  addr_out,
    output reg  [15:0] write_data_out,
    output reg         write_strobe_out,
    output reg         read_strobe_out
);
    wire [2:0]  pins_w;
    reg  [2:0]  s1_reg;
    reg  [2:0]  s2_reg;
    reg  [2:0]  s3_reg;
    reg  [2:0]  filt_reg;
    reg  [2:0]  prev_reg;
    reg  [22:0] in_sr_reg;
    reg  [15:0] out_sr_reg;
    reg  [4:0]  bit_cnt_reg;
    reg         is_read_reg;
    reg         load_reg;
    wire        sel_w;
    wire        rise_w;
    wire        fall_w;
    wire        start_w;

    // idle level of select, clock and data, one bit per pin filter
    localparam [2:0] PIN_IDLE_P = `PIN_IDLE;

    assign pins_w = {spi_select_n_in, spi_clock_in, spi_data_in};

    // three-stage synchroniser chain
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_reg <= `PIN_IDLE;
            s2_reg <= `PIN_IDLE;
            s3_reg <= `PIN_IDLE;
        end else begin
            s1_reg <= pins_w;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a pin change counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_filt
            always @(posedge clock_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    filt_reg[i] <= PIN_IDLE_P[i];
                    prev_reg[i] <= PIN_IDLE_P[i];
                end else begin
                    if (s2_reg[i] == s3_reg[i]) begin
                        filt_reg[i] <= s2_reg[i];
                    end
                    prev_reg[i] <= filt_reg[i];
                end
            end
        end
    endgenerate

    assign sel_w   = ~filt_reg[2];
    assign start_w = ~filt_reg[2] & prev_reg[2];
    assign rise_w  = sel_w & filt_reg[1] & ~prev_reg[1];
    assign fall_w  = sel_w & ~filt_reg[1] & prev_reg[1];

    // frame shifting, command decode and word strobes
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_sr_reg        <= 23'h000000;
            out_sr_reg       <= 16'h0000;
            bit_cnt_reg      <= 5'h00;
            is_read_reg      <= 1'b0;
            load_reg         <= 1'b0;
            addr_out         <= 7'h00;
            write_data_out   <= 16'h0000;
            write_strobe_out <= 1'b0;
            read_strobe_out  <= 1'b0;
            spi_data_out     <= 1'b0;
            spi_data_oe_out  <= 1'b0;
        end else begin
            write_strobe_out <= 1'b0;
            read_strobe_out  <= 1'b0;
            load_reg         <= 1'b0;
            spi_data_oe_out  <= sel_w;
            if (start_w) begin
                // status byte goes out while the command comes in
                bit_cnt_reg  <= 5'h00;
                spi_data_out <= status_byte_in[7];
                out_sr_reg   <= {status_byte_in[6:0], 9'h000};
            end else if (rise_w) begin
                // data taken from the filtered pin, never the raw one
                in_sr_reg   <= {in_sr_reg[21:0], filt_reg[0]};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == `SPI_ADDR_LAST) begin
                    addr_out        <= {in_sr_reg[5:0], filt_reg[0]};
                    is_read_reg     <= in_sr_reg[6];
                    read_strobe_out <= in_sr_reg[6];
                    load_reg        <= in_sr_reg[6];
                end
                if (bit_cnt_reg == `SPI_FRAME_LAST && !is_read_reg) begin
                    // whole word delivered in one strobe
                    write_data_out   <= {in_sr_reg[14:0], filt_reg[0]};
                    write_strobe_out <= 1'b1;
                end
            end else if (fall_w) begin
                spi_data_out <= out_sr_reg[15];
                out_sr_reg   <= {out_sr_reg[14:0], 1'b0};
            end
            if (load_reg) begin
                out_sr_reg <= read_data_in;
            end
        end
    end
endmodule

// ---- dv/rf_chan_checker_assertions.sv ----
// port relation checker for the channel/operation block
`timescale 1ns/100ps
module rf_chan_checker (
    // clock and reset
    input wire        clock_in,
    input wire        rstn_in,
    // watched ports
    input wire        spi_select_n_in,
    input wire        spi_data_oe_out,
    input wire        sync_detect_in,
    input wire        fifo_read_out,
    input wire        tx_enable_out,
    input wire        rx_enable_out,
    input wire [6:0]  carrier_channel_index_out,
    input wire [11:0] carrier_freq_mhz_out,
    input wire        packet_indication_pin_out,
    input wire        test_clock_out
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    a_freq_from_chan: assert property (
        carrier_freq_mhz_out == 12'h962 + {5'h00, carrier_channel_index_out})
        else $error("carrier frequency not base plus channel");
    a_one_direction: assert property (
        !(tx_enable_out && rx_enable_out))
        else $error("transmit and receive active together");
    a_chan_when_active: assert property (
        $changed(carrier_channel_index_out) |-> tx_enable_out || rx_enable_out)
        else $error("channel changed without an operation start");
    a_enable_in_frame: assert property (
        $changed(tx_enable_out) || $changed(rx_enable_out) |-> !spi_select_n_in)
        else $error("operation changed outside a frame");
    a_pkt_only_rx: assert property (
        packet_indication_pin_out |-> rx_enable_out)
        else $error("packet flag set outside receive");
    a_pkt_from_sync: assert property (
        $rose(packet_indication_pin_out) |-> $past(sync_detect_in))
        else $error("packet flag rose without sync");
    a_pkt_clear_read: assert property (
        $rose(fifo_read_out) && $past(packet_indication_pin_out) && !$past(sync_detect_in)
            |-> ##[0:2] !packet_indication_pin_out)
        else $error("packet flag not cleared by first read");
    a_pkt_stays_low: assert property (
        $fell(packet_indication_pin_out) && rx_enable_out
            |=> !packet_indication_pin_out [*8])
        else $error("packet flag came back in same operation");
    a_tclk_toggles: assert property (
        test_clock_out |=> !test_clock_out)
        else $error("test clock high two cycles");
    a_oe_follows_sel: assert property (
        $stable(spi_select_n_in) [*6] |-> spi_data_oe_out == !spi_select_n_in)
        else $error("data out enable not following select");
endmodule

bind rf_channel_operation_control rf_chan_checker rf_chan_checker_i (
    .clock_in                  (clock_in),
    .rstn_in                   (rstn_in),
    .spi_select_n_in           (spi_select_n_in),
    .spi_data_oe_out           (spi_data_oe_out),
    .sync_detect_in            (sync_detect_in),
    .fifo_read_out             (fifo_read_out),
    .tx_enable_out             (tx_enable_out),
    .rx_enable_out             (rx_enable_out),
    .carrier_channel_index_out (carrier_channel_index_out),
    .carrier_freq_mhz_out      (carrier_freq_mhz_out),
    .packet_indication_pin_out (packet_indication_pin_out),
    .test_clock_out            (test_clock_out)
);

// ---- dv/spi_host_model.sv ----
// host model driving select, clock and data-in spi lines of the channel block and sampling miso
`timescale 1ns/100ps
module spi_host_model (
    // spi pins
    output reg  spi_select_n_out,
    output reg  spi_clock_out,
    output reg  spi_mosi_out,
    input  wire spi_miso_in
);
    // idle levels: clock stands low between frames
    initial begin
        spi_select_n_out = 1'b1;
        spi_clock_out = 1'b0;
        spi_mosi_out = 1'b0;
    end
    // one atomic 24-bit frame, mode 0, msb first, 160 ns clock
    task xfer(input [7:0] cmd, input [15:0] wd, output [23:0] got);
        reg [23:0] sh;
        integer    i;
        begin
            sh = {cmd, wd};
            spi_select_n_out = 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                spi_mosi_out = sh[i];
                #80 spi_clock_out = 1'b1;
                got[i] = spi_miso_in;
                #80 spi_clock_out = 1'b0;
            end
            #80 spi_select_n_out = 1'b1;
            spi_mosi_out = ~spi_mosi_out; // released line shows no stale bit
            #80;
        end
    endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench of the channel/operation register block
`timescale 1ns/100ps
module tb_top;
    reg         clock_in;
    reg         rstn_in;
    reg         sync_detect_in;
    reg         fifo_threshold_in;
    reg  [7:0]  rx_fifo_data_in;
    wire        sel_n, sck, mosi, miso, fifo_read, tx_en, rx_en, pkt, fifo_flag, tclk;
    wire [6:0]  chan;
    wire [11:0] freq;
    wire [15:0] power;
    reg  [23:0] got;
    integer     n_errors;
    integer     total_checks;
    integer     highs;
    integer     pops;

    // 125 MHz clock
    always #4 clock_in = ~clock_in;

    // fifo pop pulses seen on the framer side
    always @(posedge clock_in) begin
        if (fifo_read === 1'b1) begin
            pops <= pops + 1;
        end
    end

    rf_channel_operation_control rf_channel_operation_control_i (
        .clock_in(clock_in), .rstn_in(rstn_in),
        .spi_select_n_in(sel_n), .spi_clock_in(sck), .spi_data_in(mosi),
        .spi_data_out(miso), .spi_data_oe_out(),
        .sync_detect_in(sync_detect_in), .fifo_threshold_in(fifo_threshold_in),
        .rx_fifo_data_in(rx_fifo_data_in), .fifo_read_out(fifo_read),
        .tx_enable_out(tx_en), .rx_enable_out(rx_en),
        .carrier_channel_index_out(chan), .carrier_freq_mhz_out(freq),
        .tx_power_step_out(power), .packet_indication_pin_out(pkt),
        .fifo_flag_out(fifo_flag), .test_clock_out(tclk));

    spi_host_model spi_host_model_i (
        .spi_select_n_out(sel_n), .spi_clock_out(sck),
        .spi_mosi_out(mosi), .spi_miso_in(miso));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task acc(input rd, input [6:0] a, input [15:0] d);
        begin
            @(negedge clock_in);
            spi_host_model_i.xfer({rd, a}, d, got);
        end
    endtask
    task radio(input tx, input rx, input [6:0] c);
        begin
            check({tx_en, rx_en, chan, freq}, {tx, rx, c, 12'h962 + {5'h00, c}});
        end
    endtask
    task sync_pulse;
        begin
            @(negedge clock_in) sync_detect_in = 1'b1;
            @(negedge clock_in) sync_detect_in = 1'b0;
            @(negedge clock_in);
        end
    endtask
    task count_tclk;
        begin
            highs = 0;
            repeat (8) @(negedge clock_in) highs = highs + tclk;
        end
    endtask
    task reset_dut;
        begin
            rstn_in = 1'b0;
            repeat (16) @(negedge clock_in);
            rstn_in = 1'b1;
            repeat (4) @(negedge clock_in);
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", n_errors, total_checks);
            if (n_errors == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // run limit
    initial begin
        repeat (100000) @(posedge clock_in);
        n_errors = n_errors + 1;
        $display("[FAIL] %0t ns: run limit reached", $time);
        finish_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        rstn_in = 1'b0;
        sync_detect_in = 1'b0;
        fifo_threshold_in = 1'b0;
        rx_fifo_data_in = 8'hA5;
        n_errors = 0;
        total_checks = 0;
        pops = 0;
        reset_dut;
        radio(0, 0, 7'h00);
        acc(1, 7'h07, 16'h0000); check(got[15:0], 16'h0000);
        acc(0, 7'h07, 16'h0105); radio(1, 0, 7'h05);
        acc(1, 7'h30, 16'h0000); check(got[23:21], 3'b001);
        acc(0, 7'h07, 16'h014E); radio(1, 0, 7'h4E);
        acc(0, 7'h07, 16'h0080); radio(0, 0, 7'h4E);
        acc(0, 7'h07, 16'h0027); radio(0, 0, 7'h4E);
        acc(0, 7'h07, 16'h00A7); radio(0, 1, 7'h27);
        acc(0, 7'h07, 16'h00CE); radio(0, 1, 7'h4E);
        sync_pulse; check(pkt, 1);
        acc(1, 7'h30, 16'h0000); check(got[7:5], 3'b110);
        acc(1, 7'h32, 16'h0000); check(got[7:0], 8'hA5);
        check(pops, 1);
        check(pkt, 0);
        sync_pulse; check(pkt, 0);
        acc(0, 7'h07, 16'h0000); radio(0, 0, 7'h4E);
        acc(0, 7'h07, 16'h0090); radio(0, 1, 7'h10);
        repeat (50) @(negedge clock_in);
        check(pkt, 0);
        acc(0, 7'h07, 16'h0010); radio(0, 0, 7'h10);
        acc(0, 7'h07, 16'h0181); radio(1, 0, 7'h01);
        acc(0, 7'h09, 16'h1820); check(power, 16'h1820);
        acc(0, 7'h09, 16'h1E20); acc(1, 7'h09, 16'h0000); check(got[15:0], 16'h1E20);
        acc(0, 7'h20, 16'h0002); count_tclk; check(highs, 4);
        acc(0, 7'h20, 16'h0004); count_tclk; check(highs, 0);
        acc(1, 7'h15, 16'h0000); check(got[15:0], 16'h0000);
        @(negedge clock_in) fifo_threshold_in = 1'b1;
        @(negedge clock_in); check(fifo_flag, 1);
        reset_dut;
        radio(0, 0, 7'h00); check(power, 16'h0000);
        acc(1, 7'h20, 16'h0000); check(got[15:0], 16'h0000);
        finish_test;
    end
endmodule
